//--- src/sib_map.svh
`ifndef SIB_MAP_SVH
`define SIB_MAP_SVH

// ***************************************************************
// register addresses
// ***************************************************************
`define SIB_ADDR_W        15
`define SIB_ADDR_FLAG     15'h7ff0
`define SIB_ADDR_CTRL     15'h7ff6

// ***************************************************************
// interrupt control field positions
// ***************************************************************
`define SIB_CTRL_WDOG_IRQ_EN     7
`define SIB_CTRL_ALARM_IRQ_EN    6
`define SIB_CTRL_PWRFAIL_IRQ_EN  5
`define SIB_CTRL_ALARM_BACKUP_EN 4
`define SIB_CTRL_HL              3
`define SIB_CTRL_PL              2
`define SIB_CTRL_VINT            1
`define SIB_CTRL_RST             8'h24
`define SIB_CTRL_WMASK           8'hfe

// ***************************************************************
// flag register field positions
// ***************************************************************
`define SIB_FLAG_WDOG_TIMEOUT    7
`define SIB_FLAG_ALARM_MATCH     6
`define SIB_FLAG_PWRFAIL         5

// ***************************************************************
// timing
// ***************************************************************
`define SIB_CLK_HZ        25000000
`define SIB_PULSE_MS      200
`define SIB_MS_CYCLES     (`SIB_CLK_HZ / 1000)

`endif

//--- src/sib_pkg.sv
`default_nettype none

package sib_pkg;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef logic [7:0]  sib_byte_t;
  typedef logic [14:0] sib_addr_t;

  // sampled parallel bus pins
  typedef struct packed {
    logic      ceN;
    logic      weN;
    logic      oeN;
    sib_addr_t addr;
    sib_byte_t data;
  } sib_bus_s;

  // raw interrupt sources, one bit each
  typedef struct packed {
    logic wdog;
    logic alarm;
    logic pwrfail;
  } sib_src_s;

endpackage : sib_pkg

`default_nettype wire

//--- src/sib_supervisor_irq.sv
`include "sib_map.svh"
`default_nettype none

// How it works
// [R1] three sources: watchdog, power-fail, alarm; each has enable and flag, one pin
// [R2] pin asserts when any source is active with its enable set
// [R3] reading the flag register returns the flags then clears them all
// [R4] flags clear only on a full read; a write strobe in the access keeps them
// [R5] pin driver settings sit in control bits 3 and 2
// [R6] watchdog timeout sets its flag; drives pin only when its enable is 1
// [R7] alarm match sets its flag; drives pin only when its enable is 1
// [R8] power-fail event sets its flag; drives pin only when its enable is 1
// [R9] alarm drives pin in backup only with backup enable; else needs supply above lockout
// [R10] power-fail drives pin regardless of alarm backup enable
// [R11] polarity 1: active-high push-pull, drives only above lockout
// [R12] polarity 0: active-low open-drain, still pulls low in backup
// [R13] in backup the active state can only be low
// [R14] pulse mode: one-shot of about 200 ms
// [R15] level mode: pin holds active until the flag register is read
// [R16] level mode: flag read returns pin to inactive
// [R17] pulse mode: flag read ends the pulse early
// [R18] power-on reset loads control with 24h: power-fail, active low, pulse
// [R19] host enables alarm in backup only with active-low polarity
// [R20] host must expect a new source between pin assertion and flag read
// [R21] flag bits: watchdog 7, alarm 6, power-fail 5
// [R22] control bit 1 selects power-fail threshold, 1 is the higher one
// [R23] pulse width counted on the crystal-derived clock
module sib_supervisor_irq #(
  parameter int unsigned MS_CYCLES = `SIB_MS_CYCLES
) (
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           rstn,
  // parallel memory pins
  input  wire logic           ceN,
  input  wire logic           weN,
  input  wire logic           oeN,
  input  wire sib_pkg::sib_addr_t addr,
  input  wire sib_pkg::sib_byte_t dataIn,
  output var  sib_pkg::sib_byte_t dataOut,
  output logic                dataOe,
  // internal sources, same clock
  input  wire sib_pkg::sib_src_s  srcEvent,
  // supply status from the analog monitor
  input  wire logic           vddAboveLockout,
  // interrupt pin
  output logic                intOut,
  output logic                intOe,
  // threshold select to the power monitor
  output logic                pwrfailThreshHi
);
  import sib_pkg::*;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  sib_bus_s busMeta_q;
  sib_bus_s busSync_q;
  logic     ceDly_q;
  logic     vddMeta_q;
  logic     vddOk_q;

  // two flops on every pin before use
  // address and strobes pass the same flops, so they stay aligned with the edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busMeta_q <= '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, addr: '0, data: '0};
      busSync_q <= '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, addr: '0, data: '0};
      ceDly_q   <= 1'b1;
      vddMeta_q <= 1'b0;
      vddOk_q   <= 1'b0;
    end else begin
      busMeta_q <= '{ceN: ceN, weN: weN, oeN: oeN, addr: addr, data: dataIn};
      busSync_q <= busMeta_q;
      ceDly_q   <= busSync_q.ceN;
      vddMeta_q <= vddAboveLockout;
      vddOk_q   <= vddMeta_q;
    end
  end

  // ***************************************************************
  // access tracking
  // ***************************************************************
  logic      accActive_q;
  sib_addr_t accAddr_q;
  logic      weSeen_q;
  sib_byte_t wrData_q;

  wire ceFall   = ceDly_q & ~busSync_q.ceN;
  wire ceRise   = ~ceDly_q & busSync_q.ceN;
  wire accEnd   = ceRise & accActive_q;
  wire isFlag   = (accAddr_q == `SIB_ADDR_FLAG);
  wire isCtrl   = (accAddr_q == `SIB_ADDR_CTRL);
  wire readDone = accEnd & ~weSeen_q & isFlag;  // [R4]
  wire wrDone   = accEnd & weSeen_q & isCtrl;

  // address latched at chip enable fall, write strobe remembered
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      accActive_q <= 1'b0;
      accAddr_q   <= '0;
      weSeen_q    <= 1'b0;
      wrData_q    <= '0;
    end else begin
      if (ceFall) begin
        accActive_q <= 1'b1;
        accAddr_q   <= busSync_q.addr;
        weSeen_q    <= ~busSync_q.weN;
      end else if (ceRise) begin
        accActive_q <= 1'b0;
      end else if (accActive_q && !busSync_q.weN) begin
        weSeen_q    <= 1'b1;  // [R4]
      end
      if (!busSync_q.weN) begin
        wrData_q    <= busSync_q.data;
      end
    end
  end

  // ***************************************************************
  // interrupt control register
  // ***************************************************************
  sib_byte_t ctrl_q;

  wire wdogIrqEn     = ctrl_q[`SIB_CTRL_WDOG_IRQ_EN];
  wire alarmIrqEn    = ctrl_q[`SIB_CTRL_ALARM_IRQ_EN];
  wire pwrfailIrqEn  = ctrl_q[`SIB_CTRL_PWRFAIL_IRQ_EN];
  wire alarmBackupEn = ctrl_q[`SIB_CTRL_ALARM_BACKUP_EN];
  wire hl            = ctrl_q[`SIB_CTRL_HL];   // [R5]
  wire pl            = ctrl_q[`SIB_CTRL_PL];   // [R5]

  // power-on default, written at access end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `SIB_CTRL_RST;  // [R18]
    end else if (wrDone) begin
      ctrl_q <= wrData_q & `SIB_CTRL_WMASK;
    end
  end

  // ***************************************************************
  // flags
  // ***************************************************************
  logic [2:0] flags_q;

  wire [2:0] srcBits = {srcEvent.wdog, srcEvent.alarm, srcEvent.pwrfail};
  wire [2:0] flags_d = (flags_q & ~{3{readDone}}) | srcBits;  // [R3] [R6] [R7] [R8]

  // a set in the clearing cycle survives
  // losing an event costs more than reporting it twice
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;  // [R1]
    end
  end

  // ***************************************************************
  // qualification
  // ***************************************************************
  wire wdogQ    = srcEvent.wdog & wdogIrqEn;                               // [R6]
  wire alarmQ   = srcEvent.alarm & alarmIrqEn & (alarmBackupEn | vddOk_q); // [R7] [R9]
  wire pwrfailQ = srcEvent.pwrfail & pwrfailIrqEn;                         // [R8] [R10]
  wire anyQ     = wdogQ | alarmQ | pwrfailQ;                               // [R2]
  logic anyQDly_q;
  wire trig   = anyQ & ~anyQDly_q;

  // ***************************************************************
  // pulse timer on the crystal-derived clock
  // ***************************************************************
  localparam int unsigned MS_W = $clog2(MS_CYCLES + 1);
  logic [MS_W-1:0] divCnt_q;
  logic [7:0]      msCnt_q;
  logic            intActive_q;

  wire msTick    = (divCnt_q == MS_W'(MS_CYCLES - 1));
  wire pulseDone = pl & msTick & (msCnt_q == 8'(`SIB_PULSE_MS - 1));  // [R14] [R23]
  wire clearAct  = readDone | pulseDone;                              // [R16] [R17]
  wire intAct_d  = trig | (intActive_q & ~clearAct);                  // [R15]

  // ms divider and pulse length counter
  // held at zero in level mode, so a long level interrupt never runs it past the width
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      divCnt_q <= '0;
      msCnt_q  <= '0;
    end else if (trig || !intActive_q || !pl) begin
      divCnt_q <= '0;
      msCnt_q  <= '0;
    end else if (msTick) begin
      divCnt_q <= '0;
      msCnt_q  <= msCnt_q + 8'h01;  // [R23]
    end else begin
      divCnt_q <= divCnt_q + MS_W'(1);
    end
  end

  // active state of the pin
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      anyQDly_q   <= 1'b0;
      intActive_q <= 1'b0;
    end else begin
      anyQDly_q   <= anyQ;
      intActive_q <= intAct_d;  // [R2]
    end
  end

  // ***************************************************************
  // pin driver and read data
  // ***************************************************************
  // below lockout the push-pull stage lets go rather than drive high
  wire ppOut = intActive_q & vddOk_q;                   // [R11] [R13]
  wire pinO  = hl ? ppOut : 1'b0;                       // [R12]
  wire pinE  = hl ? vddOk_q : intActive_q;              // [R11] [R12]
  wire [7:0] flagByte = {flags_q, 5'h00};               // [R21]
  wire [7:0] rdMux = isFlag ? flagByte : (isCtrl ? ctrl_q : 8'h00);
  wire rdDrive = accActive_q & ~weSeen_q & ~busSync_q.oeN & busSync_q.weN;

  // every output from a flop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      intOut          <= 1'b0;
      intOe           <= 1'b0;
      dataOut         <= '0;
      dataOe          <= 1'b0;
      pwrfailThreshHi <= 1'b0;
    end else begin
      intOut          <= pinO;
      intOe           <= pinE;
      dataOut         <= rdMux;
      dataOe          <= rdDrive;
      pwrfailThreshHi <= ctrl_q[`SIB_CTRL_VINT];  // [R22]
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  flag_clear_a : assert property ( // [R3]
    readDone && srcBits == 3'b000 |=> flags_q == 3'b000)
    else $error("flags not cleared by read");

  flag_keep_a : assert property ( // [R4]
    accEnd && weSeen_q && srcBits == 3'b000 |=> flags_q == $past(flags_q))
    else $error("flags changed by aborted read");

  src_set_a : assert property ( // [R6]
    srcEvent.wdog |=> flags_q[2])
    else $error("watchdog flag not set");

  irq_start_a : assert property ( // [R2]
    trig |=> intActive_q ##1 (intOe || intOut || hl))
    else $error("qualified source did not assert pin");

  alarm_gate_a : assert property ( // [R9]
    !intActive_q && !anyQDly_q && !wdogQ && !pwrfailQ && srcEvent.alarm && !alarmBackupEn && !vddOk_q
    |=> !intActive_q)
    else $error("alarm asserted pin below lockout");

  od_drive_a : assert property ( // [R12]
    !hl && intActive_q && !wrDone |=> intOe && !intOut)
    else $error("open drain not pulling low");

  high_lockout_a : assert property ( // [R13]
    intOut |-> $past(vddOk_q) && $past(hl))
    else $error("pin driven high without supply");

  level_hold_a : assert property ( // [R15]
    !pl && intActive_q && !readDone && !wrDone |=> intActive_q)
    else $error("level interrupt dropped early");

  pulse_cut_a : assert property ( // [R17]
    intActive_q && readDone && !trig |=> !intActive_q)
    else $error("read did not end pulse");

  pulse_len_a : assert property ( // [R14]
    intActive_q |-> msCnt_q < 8'(`SIB_PULSE_MS))
    else $error("pulse longer than its width");

  ctrl_reset_a : assert property ( // [R18]
    $rose(rstn) |-> ctrl_q == `SIB_CTRL_RST)
    else $error("control default lost");

  alarm_set_a : assert property ( // [R7]
    srcEvent.alarm |=> flags_q[1])
    else $error("alarm flag not set");

  pwrfail_set_a : assert property ( // [R8]
    srcEvent.pwrfail |=> flags_q[0])
    else $error("power-fail flag not set");

  enable_gate_a : assert property ( // [R2] [R6]
    !intActive_q && !(srcEvent.wdog && wdogIrqEn) && !(srcEvent.alarm && alarmIrqEn)
    && !(srcEvent.pwrfail && pwrfailIrqEn) |=> !intActive_q)
    else $error("disabled source asserted pin");

  pwrfail_any_a : assert property ( // [R10]
    srcEvent.pwrfail && pwrfailIrqEn && !anyQDly_q |=> intActive_q)
    else $error("power-fail did not assert pin");

  wdog_backup_a : assert property ( // [R9]
    srcEvent.wdog && wdogIrqEn && !anyQDly_q |=> intActive_q)
    else $error("watchdog gated by supply");

  level_clear_a : assert property ( // [R16]
    !pl && intActive_q && readDone && !trig |=> !intActive_q)
    else $error("read did not release level pin");

  pulse_end_a : assert property ( // [R14]
    pulseDone && !trig |=> !intActive_q)
    else $error("pulse not ended at its width");

  flag_hold_a : assert property ( // [R4]
    !readDone && srcBits == 3'b000 |=> flags_q == $past(flags_q))
    else $error("flags changed without a read");

  push_pull_a : assert property ( // [R11]
    hl && vddOk_q |=> intOe && intOut == $past(intActive_q))
    else $error("push-pull pin wrong above lockout");

  backup_float_a : assert property ( // [R13]
    hl && !vddOk_q |=> !intOe && !intOut)
    else $error("pin driven high in backup");

  flag_data_a : assert property ( // [R21]
    isFlag |=> dataOut == {$past(flags_q), 5'h00})
    else $error("flag byte layout wrong");

  thresh_out_a : assert property ( // [R22]
    1'b1 |=> pwrfailThreshHi == $past(ctrl_q[`SIB_CTRL_VINT]))
    else $error("threshold select not passed on");

  write_quiet_a : assert property ( // [R4]
    weSeen_q |=> !dataOe)
    else $error("data driven after write strobe");

  cov_read_c  : cover property (readDone && flags_q != 3'b000);
  cov_pulse_c : cover property (pulseDone);
  cov_write_c : cover property (wrDone);
  cov_abort_c : cover property (accEnd && weSeen_q && isFlag);
  cov_backup_c : cover property (intActive_q && !vddOk_q && !hl);

endmodule : sib_supervisor_irq

`default_nettype wire

//--- verif/sib_host_model.sv
`default_nettype none

// ******
// host side of the parallel bus and interrupt pin
// ******
module sib_host_model (
  // clock
  input  wire logic               mclk,
  // parallel bus pins
  output var  logic               ceN,
  output var  logic               weN,
  output var  logic               oeN,
  output var  sib_pkg::sib_addr_t addr,
  output var  sib_pkg::sib_byte_t dataIn,
  input  wire sib_pkg::sib_byte_t dataOut,
  input  wire logic               dataOe,
  // interrupt pin
  input  wire logic               intOut,
  input  wire logic               intOe,
  output wire logic               intPin
);
  timeunit 1ns;
  timeprecision 1ns;
  import sib_pkg::*;

  // board pull-up: a released open-drain pin reads high
  assign intPin = intOe ? intOut : 1'b1;

  // bus idles deselected
  initial begin
    ceN    = 1'b1;
    weN    = 1'b1;
    oeN    = 1'b1;
    addr   = '0;
    dataIn = '0;
  end

  // one byte access; brk drops the write strobe inside a read
  task automatic access(input sib_addr_t a, input logic wr, input sib_byte_t d,
                        input logic brk, output sib_byte_t rd);
    @(negedge mclk);
    addr   = a;
    dataIn = d;
    ceN    = 1'b0;
    oeN    = wr;
    repeat (6) @(negedge mclk);
    rd     = dataOe ? dataOut : ~dataOut; // an undriven bus never reads as valid data
    weN    = ~(wr | brk);
    repeat (3) @(negedge mclk);
    weN    = 1'b1;
    @(negedge mclk);
    ceN    = 1'b1; // whole cycle ends with a precharge
    oeN    = 1'b1;
    addr   = ~a;
    dataIn = ~d;
    repeat (5) @(negedge mclk);
  endtask : access
endmodule : sib_host_model

`default_nettype wire

//--- verif/supervisor_interrupt_block_test.sv
`include "sib_map.svh"
`default_nettype none

module supervisor_interrupt_block_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sib_pkg::*;

  // ******
  // signals
  // ******
  localparam int MSC   = 4;
  localparam int PULSE = `SIB_PULSE_MS * MSC;
  logic       mclk, rstn, vddOk, thrHi, dataOe, intOut, intOe, intPin;
  logic       ceN, weN, oeN;
  sib_addr_t  addr;
  sib_byte_t  dataIn, dataOut, rd, ctrl;
  sib_src_s   src;
  logic [2:0] s;
  int         error_cnt, check_count, cyc;
  sib_byte_t  bkCtrl[5] = '{8'h40, 8'h50, 8'h20, 8'h30, 8'h28};
  logic [2:0] bkSrc[5]  = '{3'h2, 3'h2, 3'h1, 3'h1, 3'h1};
  logic       bkPin[5]  = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

  // ******
  // design and host
  // ******
  sib_supervisor_irq #(.MS_CYCLES(MSC)) u_dut (
    .mclk(mclk), .rstn(rstn), .ceN(ceN), .weN(weN), .oeN(oeN), .addr(addr),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .srcEvent(src),
    .vddAboveLockout(vddOk), .intOut(intOut), .intOe(intOe), .pwrfailThreshHi(thrHi));

  sib_host_model u_host (
    .mclk(mclk), .ceN(ceN), .weN(weN), .oeN(oeN), .addr(addr), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .intOut(intOut), .intOe(intOe), .intPin(intPin));

  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ******
  // helpers
  // ******
  function automatic sib_byte_t expFlags(input logic [2:0] v);
    return {v, 5'h00};
  endfunction : expFlags

  // expected wire level, pull-up included
  function automatic logic expPin(input sib_byte_t c, input logic act, input logic vdd);
    return c[3] ? (vdd ? act : 1'b1) : ~act;
  endfunction : expPin

  task automatic chk(input string what, input sib_byte_t exp, input sib_byte_t got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic chkBit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s exp %b got %b", what, exp, got);
    end
  endtask : chkBit

  task automatic wr(input sib_addr_t a, input sib_byte_t d);
    u_host.access(a, 1'b1, d, 1'b0, rd);
  endtask : wr

  task automatic rdr(input sib_addr_t a);
    u_host.access(a, 1'b0, 8'h00, 1'b0, rd);
  endtask : rdr

  // one-cycle source event, then let flag and pin settle
  task automatic fire(input logic [2:0] v);
    @(negedge mclk);
    src = sib_src_s'(v);
    @(negedge mclk);
    src = '0;
    repeat (3) @(negedge mclk);
  endtask : fire

  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // ******
  // main sequence
  // ******
  initial begin
    rstn  = 1'b0;
    vddOk = 1'b1;
    src   = '0;
    void'($urandom(31061));
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    repeat (3) @(negedge mclk);
    rdr(`SIB_ADDR_CTRL);
    chk("ctrl reset", 8'h24, rd);
    chkBit("thresh reset", 1'b0, thrHi);
    chkBit("pin idle", 1'b1, intPin);
    // default pulse runs its full width, then a read cuts one short
    fire(3'h1);
    chkBit("pulse start", 1'b0, intPin);
    repeat (PULSE - 20) @(negedge mclk);
    chkBit("pulse hold", 1'b0, intPin);
    repeat (40) @(negedge mclk);
    chkBit("pulse end", 1'b1, intPin);
    rdr(`SIB_ADDR_FLAG);
    chk("pulse flag", 8'h20, rd);
    fire(3'h1);
    repeat (20) @(negedge mclk);
    rdr(`SIB_ADDR_FLAG);
    chk("early flag", 8'h20, rd);
    chkBit("early end", 1'b1, intPin);
    // aborted read keeps flags; a late source joins them
    wr(`SIB_ADDR_CTRL, 8'h20);
    fire(3'h1);
    u_host.access(`SIB_ADDR_FLAG, 1'b0, 8'h00, 1'b1, rd);
    chkBit("level hold", 1'b0, intPin);
    fire(3'h4);
    rdr(`SIB_ADDR_FLAG);
    chk("kept flags", 8'ha0, rd);
    chkBit("level clear", 1'b1, intPin);
    // writes to the flag register and to an unmapped place are ignored
    wr(`SIB_ADDR_FLAG, 8'hff);
    wr(15'h0100, 8'h00);
    rdr(`SIB_ADDR_FLAG);
    chk("flag ro", 8'h00, rd);
    rdr(`SIB_ADDR_CTRL);
    chk("ctrl kept", 8'h20, rd);
    // supply below lockout
    for (int i = 0; i < 5; i++) begin
      wr(`SIB_ADDR_CTRL, bkCtrl[i]); // alarm backup only with active low
      vddOk = 1'b0;
      repeat (4) @(negedge mclk);
      fire(bkSrc[i]);
      chkBit("backup pin", bkPin[i], intPin);
      vddOk = 1'b1;
      repeat (4) @(negedge mclk);
      rdr(`SIB_ADDR_FLAG);
      chk("backup flag", expFlags(bkSrc[i]), rd);
    end
    // random enables, polarity and sources in level mode
    for (int i = 0; i < 16; i++) begin
      ctrl = 8'($urandom) & 8'hfb;
      if (ctrl[6] && ctrl[4]) ctrl[3] = 1'b0; // alarm backup only with active low
      s    = 3'($urandom_range(7, 1));
      wr(`SIB_ADDR_CTRL, ctrl);
      rdr(`SIB_ADDR_CTRL);
      chk("ctrl rw", ctrl & 8'hfe, rd);
      chkBit("thresh", ctrl[1], thrHi);
      fire(s);
      chkBit("pin on", expPin(ctrl, |(s & ctrl[7:5]), 1'b1), intPin);
      rdr(`SIB_ADDR_FLAG);
      chk("flags", expFlags(s), rd);
      chkBit("pin off", expPin(ctrl, 1'b0, 1'b1), intPin);
      rdr(`SIB_ADDR_FLAG);
      chk("flags clr", 8'h00, rd);
    end
    finish_test();
  end
endmodule : supervisor_interrupt_block_test

`default_nettype wire
